// ### inc/omc_pkg.sv

package omc_pkg;

   // ----------------------------------------
   // Command codes and pages
   // ----------------------------------------
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_NOM_VID   = 8'h21;
   localparam logic [7:0] CMD_MLOW_VID  = 8'h26;
   localparam logic [7:0] PAGE_A        = 8'h00;
   localparam logic [7:0] PAGE_B        = 8'h01;
   localparam logic [7:0] PAGE_ALL      = 8'hFF;

   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int         VID_W       = 8;
   localparam int         WORD_W      = 16;
   localparam int         OP_ON       = 7;
   localparam int         MRG_HI      = 5;
   localparam int         MRG_LO      = 2;
   localparam logic [7:0] OP_WMASK    = 8'hBF;
   localparam logic [7:0] OP_RESET    = 8'h00;
   localparam logic [7:0] MLOW_RESET  = 8'h00;
   localparam logic [7:0] VID_UPPER   = 8'h00;
   localparam logic [3:0] MRG_OFF      = 4'h0;
   localparam logic [3:0] MRG_LOW_IGN  = 4'h5;
   localparam logic [3:0] MRG_LOW_ACT  = 4'h6;
   localparam logic [3:0] MRG_HIGH_IGN = 4'h9;
   localparam logic [3:0] MRG_HIGH_ACT = 4'hA;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int STEP_TIME_NS  = 1000;
   localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {SEL_NOM, SEL_LOW, SEL_HIGH} omc_sel_e;

   function automatic omc_sel_e margin_sel(input logic [3:0] code);
      case (code)
         MRG_LOW_IGN, MRG_LOW_ACT:   margin_sel = SEL_LOW;
         MRG_HIGH_IGN, MRG_HIGH_ACT: margin_sel = SEL_HIGH;
         default:                    margin_sel = SEL_NOM;
      endcase
   endfunction : margin_sel

   function automatic logic margin_ignore(input logic [3:0] code);
      margin_ignore = (code == MRG_LOW_IGN) || (code == MRG_HIGH_IGN);
   endfunction : margin_ignore

   function automatic logic margin_act(input logic [3:0] code);
      margin_act = (code == MRG_LOW_ACT) || (code == MRG_HIGH_ACT);
   endfunction : margin_act

endpackage : omc_pkg

// ### src/omc_slew.sv
`timescale 1ns/1ps
`default_nettype none

module omc_slew #(
   parameter int STEP_CYCLES = omc_pkg::STEP_CYCLES
) (
   input  wire logic                     clock,
   input  wire logic                     rstn,
   input  wire logic                     snap,
   input  wire logic [omc_pkg::VID_W-1:0] target,
   output logic      [omc_pkg::VID_W-1:0] cur_ff,
   output logic                          busy_ff
);

   typedef enum logic {SLW_HOLD, SLW_WAIT} omc_slw_e;

   omc_slw_e    state_ff;
   logic [15:0] cnt_ff;

   // ----------------------------------------
   // One VID step per interval
   // ----------------------------------------
   // Snap while not converting: there is no output to ramp
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= SLW_HOLD;
         cnt_ff   <= 16'h0000;
         cur_ff   <= 8'h00;
      end
      else if (snap)
      begin
         state_ff <= SLW_HOLD;
         cnt_ff   <= 16'h0000;
         cur_ff   <= target;
      end
      else
      begin
         case (state_ff)
            SLW_HOLD:
            begin
               cnt_ff <= 16'h0000;
               if (target != cur_ff)
                  state_ff <= SLW_WAIT;
            end
            SLW_WAIT:
            begin
               if (cnt_ff >= 16'(STEP_CYCLES - 1))
               begin
                  cnt_ff   <= 16'h0000;
                  state_ff <= SLW_HOLD;
                  if (target > cur_ff)
                     cur_ff <= cur_ff + 8'h01;
                  else if (target < cur_ff)
                     cur_ff <= cur_ff - 8'h01;
               end
               else
                  cnt_ff <= cnt_ff + 16'h0001;
            end
            default: state_ff <= SLW_HOLD;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         busy_ff <= 1'b0;
      else
         busy_ff <= !snap && (target != cur_ff);
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   step_size_a: assert property (@(posedge clock) disable iff (!rstn)
      !$past(snap) && $changed(cur_ff) |-> (cur_ff == $past(cur_ff) + 8'h01) || (cur_ff == $past(cur_ff) - 8'h01))
      else $error("ramp moved more than one step");

endmodule : omc_slew

`default_nettype wire

// ### src/omc_margin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module omc_margin_ctrl #(
   parameter int STEP_CYCLES = omc_pkg::STEP_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [7:0]  page_code,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic        cmd_word,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic             rsp_valid_ff,
   output logic             rsp_error_ff,
   output logic      [15:0] rsp_rdata_ff,
   input  wire logic        onoff_use_cmd,
   input  wire logic        onoff_use_pin,
   input  wire logic        input_ok,
   input  wire logic        chan_a_enable_pin,
   input  wire logic        chan_b_enable_pin,
   input  wire logic [7:0]  vout_max_vid,
   input  wire logic [7:0]  nvm_nominal_vid_a,
   input  wire logic [7:0]  nvm_nominal_vid_b,
   input  wire logic [7:0]  margin_high_vid_a,
   input  wire logic [7:0]  margin_high_vid_b,
   input  wire logic [1:0]  vout_warn_clr,
   output logic      [1:0]  conv_en_ff,
   output logic      [1:0]  ovuv_mask_ff,
   output logic      [1:0]  vout_max_warn_ff,
   output logic      [1:0]  ramp_busy,
   output logic      [7:0]  vout_vid_a,
   output logic      [7:0]  vout_vid_b
);

   localparam int NCH = 2;

   logic [7:0]  op_ff       [NCH];
   logic [7:0]  nom_ff      [NCH];
   logic [7:0]  mlow_ff     [NCH];
   logic [7:0]  sel_tgt_ff  [NCH];
   logic [7:0]  cur_vid     [NCH];
   logic [7:0]  nvm_vid     [NCH];
   logic [7:0]  mhigh_vid   [NCH];
   logic [7:0]  nxt_tgt     [NCH];
   logic [NCH-1:0] pin_raw;
   logic [NCH-1:0] sy1_ff;
   logic [NCH-1:0] sy2_ff;
   logic [NCH-1:0] sy3_ff;
   logic [NCH-1:0] pin_ok_ff;
   logic [NCH-1:0] warn_set;
   logic        loaded_ff;
   logic [1:0]  hit;
   logic        is_op;
   logic        is_nom;
   logic        is_mlow;
   logic        size_ok;
   logic        acc_ok;
   logic        wr_ok;
   logic        rd_ch;
   logic [15:0] rd_val;

   assign pin_raw      = {chan_b_enable_pin, chan_a_enable_pin};
   assign nvm_vid[0]   = nvm_nominal_vid_a;
   assign nvm_vid[1]   = nvm_nominal_vid_b;
   assign mhigh_vid[0] = margin_high_vid_a;
   assign mhigh_vid[1] = margin_high_vid_b;
   assign vout_vid_a   = cur_vid[0];
   assign vout_vid_b   = cur_vid[1];

   function automatic logic [1:0] page_hit(input logic [7:0] p);
      case (p)
         omc_pkg::PAGE_A:   page_hit = 2'h1;
         omc_pkg::PAGE_B:   page_hit = 2'h2;
         omc_pkg::PAGE_ALL: page_hit = 2'h3;
         default:           page_hit = 2'h0;
      endcase
   endfunction : page_hit

   function automatic logic [7:0] clamp_max(input logic [7:0] v, input logic [7:0] m);
      clamp_max = (v > m) ? m : v;
   endfunction : clamp_max

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   // Wrong transaction size, unknown code or page is refused and flagged
   always_comb
   begin
      hit     = page_hit(page_code);
      is_op   = (cmd_code == omc_pkg::CMD_OPERATION);
      is_nom  = (cmd_code == omc_pkg::CMD_NOM_VID);
      is_mlow = (cmd_code == omc_pkg::CMD_MLOW_VID);
      size_ok = (is_op && !cmd_word) || ((is_nom || is_mlow) && cmd_word);
      acc_ok  = cmd_valid && size_ok && (hit != 2'h0) && loaded_ff;
      wr_ok   = acc_ok && cmd_write;
      rd_ch   = (page_code == omc_pkg::PAGE_B);
   end

   // Page FFh reads answer with channel A
   always_comb
   begin
      rd_val = 16'h0000;
      if (is_op)
         rd_val = {8'h00, op_ff[rd_ch]};
      else if (is_nom)
         rd_val = {omc_pkg::VID_UPPER, nom_ff[rd_ch]};
      else if (is_mlow)
         rd_val = {omc_pkg::VID_UPPER, mlow_ff[rd_ch]};
   end

   // ----------------------------------------
   // Response
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rsp_valid_ff <= 1'b0;
         rsp_error_ff <= 1'b0;
         rsp_rdata_ff <= 16'h0000;
      end
      else
      begin
         rsp_valid_ff <= cmd_valid;
         rsp_error_ff <= cmd_valid && !acc_ok;
         rsp_rdata_ff <= (acc_ok && !cmd_write) ? rd_val : 16'h0000;
      end
   end

   // NVM value is caught on the first edge after release, not under reset
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         loaded_ff <= 1'b0;
      else
         loaded_ff <= 1'b1;
   end

   // ----------------------------------------
   // Per-channel registers and target logic
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_ch
         logic [3:0] mcode;
         omc_pkg::omc_sel_e sel;

         // Pin needs settling: a change counts once two stages agree
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
            begin
               sy1_ff[gi]    <= 1'b0;
               sy2_ff[gi]    <= 1'b0;
               sy3_ff[gi]    <= 1'b0;
               pin_ok_ff[gi] <= 1'b0;
            end
            else
            begin
               sy1_ff[gi] <= pin_raw[gi];
               sy2_ff[gi] <= sy1_ff[gi];
               sy3_ff[gi] <= sy2_ff[gi];
               if (sy2_ff[gi] == sy3_ff[gi])
                  pin_ok_ff[gi] <= sy3_ff[gi];
            end
         end

         // Low bits stay writable; the host writes 00b there except in the FFh operation write
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
               op_ff[gi] <= omc_pkg::OP_RESET;
            else if (wr_ok && is_op && hit[gi])
               op_ff[gi] <= cmd_wdata[7:0] & omc_pkg::OP_WMASK;
         end

         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
               nom_ff[gi] <= 8'h00;
            else if (!loaded_ff)
               nom_ff[gi] <= clamp_max(nvm_vid[gi], vout_max_vid);
            else if (wr_ok && is_nom && hit[gi])
               nom_ff[gi] <= clamp_max(cmd_wdata[7:0], vout_max_vid);
            else
               nom_ff[gi] <= clamp_max(nom_ff[gi], vout_max_vid);
         end

         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
               mlow_ff[gi] <= omc_pkg::MLOW_RESET;
            else if (wr_ok && is_mlow && hit[gi])
               mlow_ff[gi] <= cmd_wdata[7:0];
         end

         always_comb
         begin
            mcode = onoff_use_cmd ? op_ff[gi][omc_pkg::MRG_HI:omc_pkg::MRG_LO] : omc_pkg::MRG_OFF;
            sel   = omc_pkg::margin_sel(mcode);
            case (sel)
               omc_pkg::SEL_LOW:  nxt_tgt[gi] = mlow_ff[gi];
               omc_pkg::SEL_HIGH: nxt_tgt[gi] = mhigh_vid[gi];
               default:           nxt_tgt[gi] = nom_ff[gi];
            endcase
            warn_set[gi] = omc_pkg::margin_act(mcode) && (nxt_tgt[gi] > nom_ff[gi]);
         end

         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
            begin
               sel_tgt_ff[gi]   <= 8'h00;
               ovuv_mask_ff[gi] <= 1'b0;
            end
            else
            begin
               sel_tgt_ff[gi]   <= nxt_tgt[gi];
               ovuv_mask_ff[gi] <= omc_pkg::margin_ignore(mcode);
            end
         end

         // Set beats clear so a warning is never lost
         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
               vout_max_warn_ff[gi] <= 1'b0;
            else
               vout_max_warn_ff[gi] <= warn_set[gi] || (vout_max_warn_ff[gi] && !vout_warn_clr[gi]);
         end

         always_ff @(posedge clock or negedge rstn)
         begin
            if (!rstn)
               conv_en_ff[gi] <= 1'b0;
            else
               conv_en_ff[gi] <= (!onoff_use_cmd || op_ff[gi][omc_pkg::OP_ON])
                                 && (!onoff_use_pin || pin_ok_ff[gi]) && input_ok;
         end

         omc_slew #(
            .STEP_CYCLES (STEP_CYCLES)
         ) u_slew (
            .clock   (clock),
            .rstn    (rstn),
            .snap    (!conv_en_ff[gi]),
            .target  (sel_tgt_ff[gi]),
            .cur_ff  (cur_vid[gi]),
            .busy_ff (ramp_busy[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence wr_all_nom_s;
      cmd_valid && cmd_write && cmd_word && cmd_code == omc_pkg::CMD_NOM_VID
         && page_code == omc_pkg::PAGE_ALL && loaded_ff;
   endsequence

   on_gate_a: assert property (conv_en_ff[0] |-> $past(!onoff_use_cmd || op_ff[0][omc_pkg::OP_ON]))
      else $error("conversion without on bit");
   start_cond_a: assert property (conv_en_ff[1] |-> $past(input_ok && (!onoff_use_pin || pin_ok_ff[1])))
      else $error("conversion without start conditions");
   nominal_sel_a: assert property ($past(g_ch[0].mcode == omc_pkg::MRG_OFF) |-> sel_tgt_ff[0] == $past(nom_ff[0]))
      else $error("margin off target not nominal");
   low_ignore_a: assert property (g_ch[0].mcode == omc_pkg::MRG_LOW_IGN
      |=> sel_tgt_ff[0] == $past(mlow_ff[0]) && ovuv_mask_ff[0])
      else $error("margin low ignore wrong");
   low_act_a: assert property (g_ch[1].mcode == omc_pkg::MRG_LOW_ACT
      |=> sel_tgt_ff[1] == $past(mlow_ff[1]) && !ovuv_mask_ff[1])
      else $error("margin low act wrong");
   high_ignore_a: assert property (g_ch[0].mcode == omc_pkg::MRG_HIGH_IGN
      |=> sel_tgt_ff[0] == $past(margin_high_vid_a) && ovuv_mask_ff[0])
      else $error("margin high ignore wrong");
   high_act_a: assert property (g_ch[1].mcode == omc_pkg::MRG_HIGH_ACT
      |=> sel_tgt_ff[1] == $past(margin_high_vid_b) && !ovuv_mask_ff[1])
      else $error("margin high act wrong");
   warn_hold_a: assert property (warn_set[0] |=> vout_max_warn_ff[0] ##1
      (vout_max_warn_ff[0] || $past(vout_warn_clr[0])))
      else $error("max warning not raised or held");
   nom_limit_a: assert property ($past(loaded_ff) && $stable(vout_max_vid) |-> nom_ff[0] <= vout_max_vid)
      else $error("nominal above maximum");
   size_err_a: assert property (cmd_valid && (is_nom || is_mlow) && !cmd_word
      |=> rsp_valid_ff && rsp_error_ff)
      else $error("byte access to word register accepted");
   both_pages_a: assert property (wr_all_nom_s |=> nom_ff[0] == nom_ff[1])
      else $error("page all did not reach both channels");
   mlow_reset_a: assert property ($rose(loaded_ff) |-> mlow_ff[1] == omc_pkg::MLOW_RESET)
      else $error("margin low reset value wrong");
   op_byte_a: assert property (cmd_valid && is_op && cmd_word |=> rsp_error_ff && $stable(op_ff[0]))
      else $error("word access to operation accepted");
   upper_zero_a: assert property (rsp_valid_ff && !rsp_error_ff |-> rsp_rdata_ff[15:8] == omc_pkg::VID_UPPER)
      else $error("upper byte not zero");

endmodule : omc_margin_ctrl

`default_nettype wire

// ### sim/omc_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host master model
// ----------------------------------------
module omc_host (
   input  wire logic        clock,
   input  wire logic        rsp_valid_ff,
   input  wire logic        rsp_error_ff,
   input  wire logic [15:0] rsp_rdata_ff,
   output logic      [7:0]  page_code,
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic             cmd_word,
   output logic      [7:0]  cmd_code,
   output logic      [15:0] cmd_wdata
);
   initial
   begin
      page_code = omc_pkg::PAGE_A;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_word  = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // Page is always set before a paged access
   task automatic set_page(input logic [7:0] p);
      @(posedge clock);
      #1 page_code = p;
   endtask : set_page

   // Caller picks the size so that refusals can be provoked
   task automatic xfer(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d,
                       output logic ok, output logic err, output logic [15:0] rd);
      @(posedge clock);
      #1;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_word  = wd;
      cmd_code  = c;
      cmd_wdata = d;
      @(posedge clock);
      #1;
      ok        = rsp_valid_ff;
      err       = rsp_error_ff;
      rd        = rsp_rdata_ff;
      cmd_valid = 1'b0;
      // Released code and data lines show a changed pattern; write and word flags keep the stale value
      cmd_code  = ~c;
      cmd_wdata = ~d;
   endtask : xfer
endmodule : omc_host

`default_nettype wire

// ### sim/omc_margin_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module omc_margin_ctrl_test;
   // Short step keeps ramps to about a hundred cycles
   localparam int STEP = 2;
   logic        clock, rstn, cmd_valid, cmd_write, cmd_word, rsp_valid_ff, rsp_error_ff;
   logic        onoff_use_cmd, onoff_use_pin, input_ok, chan_a_enable_pin, chan_b_enable_pin;
   logic [7:0]  page_code, cmd_code, vout_max_vid, nvm_nominal_vid_a, nvm_nominal_vid_b;
   logic [7:0]  margin_high_vid_a, margin_high_vid_b, vout_vid_a, vout_vid_b;
   logic [15:0] cmd_wdata, rsp_rdata_ff;
   logic [1:0]  vout_warn_clr, conv_en_ff, ovuv_mask_ff, vout_max_warn_ff, ramp_busy;
   int          n_mismatch, checked;

   omc_margin_ctrl #(.STEP_CYCLES(STEP)) dut (
      .clock(clock), .rstn(rstn), .page_code(page_code), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .rsp_valid_ff(rsp_valid_ff), .rsp_error_ff(rsp_error_ff), .rsp_rdata_ff(rsp_rdata_ff),
      .onoff_use_cmd(onoff_use_cmd), .onoff_use_pin(onoff_use_pin), .input_ok(input_ok),
      .chan_a_enable_pin(chan_a_enable_pin), .chan_b_enable_pin(chan_b_enable_pin),
      .vout_max_vid(vout_max_vid), .nvm_nominal_vid_a(nvm_nominal_vid_a),
      .nvm_nominal_vid_b(nvm_nominal_vid_b), .margin_high_vid_a(margin_high_vid_a),
      .margin_high_vid_b(margin_high_vid_b), .vout_warn_clr(vout_warn_clr),
      .conv_en_ff(conv_en_ff), .ovuv_mask_ff(ovuv_mask_ff), .vout_max_warn_ff(vout_max_warn_ff),
      .ramp_busy(ramp_busy), .vout_vid_a(vout_vid_a), .vout_vid_b(vout_vid_b));

   omc_host host (
      .clock(clock), .rsp_valid_ff(rsp_valid_ff), .rsp_error_ff(rsp_error_ff),
      .rsp_rdata_ff(rsp_rdata_ff), .page_code(page_code), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   task automatic acc(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d,
                      input logic e_err, input logic [15:0] e_rd);
      logic        ok;
      logic        err;
      logic [15:0] rd;
      host.xfer(wr, wd, c, d, ok, err, rd);
      chk({14'h0000, ok, err}, {14'h0000, 1'b1, e_err});
      chk(rd, e_rd);
   endtask : acc

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b0, 16'h0060);
      acc(1'b0, 1'b1, 8'h26, 16'h0000, 1'b0, 16'h0000);
      acc(1'b0, 1'b0, 8'h01, 16'h0000, 1'b0, 16'h0000);
      chk({14'h0000, conv_en_ff}, 16'h0000);
      host.set_page(8'h01);
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b0, 16'h00A0);
   endtask : t_reset

   task automatic t_access;
      host.set_page(8'h00);
      acc(1'b1, 1'b1, 8'h21, 16'h1255, 1'b0, 16'h0000);
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b0, 16'h0055);
      acc(1'b1, 1'b1, 8'h21, 16'h00F0, 1'b0, 16'h0000);
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b0, 16'h00A0);
      acc(1'b0, 1'b0, 8'h26, 16'h0000, 1'b1, 16'h0000);
      acc(1'b1, 1'b1, 8'h01, 16'h0080, 1'b1, 16'h0000);
      acc(1'b0, 1'b0, 8'h22, 16'h0000, 1'b1, 16'h0000);
      acc(1'b1, 1'b0, 8'h01, 16'h00FF, 1'b0, 16'h0000);
      acc(1'b0, 1'b0, 8'h01, 16'h0000, 1'b0, 16'h00BF);
      acc(1'b1, 1'b0, 8'h01, 16'h0000, 1'b0, 16'h0000);
      // Enable follows the operation write by one registered stage
      cyc(1);
      chk({14'h0000, conv_en_ff}, 16'h0000);
      host.set_page(8'h02);
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b1, 16'h0000);
   endtask : t_access

   task automatic t_page;
      host.set_page(8'hFF);
      acc(1'b1, 1'b1, 8'h21, 16'h0033, 1'b0, 16'h0000);
      acc(1'b1, 1'b1, 8'h26, 16'h0011, 1'b0, 16'h0000);
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b0, 16'h0033);
      host.set_page(8'h01);
      acc(1'b0, 1'b1, 8'h21, 16'h0000, 1'b0, 16'h0033);
      acc(1'b0, 1'b1, 8'h26, 16'h0000, 1'b0, 16'h0011);
   endtask : t_page

   task automatic t_conv;
      host.set_page(8'h00);
      input_ok = 1'b0;
      acc(1'b1, 1'b0, 8'h01, 16'h0080, 1'b0, 16'h0000);
      cyc(3);
      chk({14'h0000, conv_en_ff}, 16'h0000);
      input_ok = 1'b1;
      cyc(3);
      chk({14'h0000, conv_en_ff}, 16'h0001);
      onoff_use_pin = 1'b1;
      cyc(6);
      chk({14'h0000, conv_en_ff}, 16'h0000);
      chan_a_enable_pin = 1'b1;
      cyc(6);
      chk({14'h0000, conv_en_ff}, 16'h0001);
   endtask : t_conv

   task automatic t_ramp;
      int cnt;
      cnt = 0;
      acc(1'b1, 1'b0, 8'h01, 16'h0094, 1'b0, 16'h0000);
      cyc(2);
      chk({15'h0000, ramp_busy[0]}, 16'h0001);
      while (ramp_busy[0] !== 1'b0 && cnt < 300)
      begin
         cyc(1);
         cnt++;
      end
      if (cnt >= 300)
      begin
         n_mismatch++;
         complete_run();
      end
      chk({8'h00, vout_vid_a}, 16'h0011);
      chk({15'h0000, cnt >= 16'h0022 * STEP - 6}, 16'h0001);
   endtask : t_ramp

   task automatic t_margin;
      logic [3:0] codes [6] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'hA, 4'h3};
      logic [3:0] c;
      // Both pages at once so channel B margin paths are exercised too
      host.set_page(8'hFF);
      chan_b_enable_pin = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         c = codes[i];
         acc(1'b1, 1'b0, 8'h01, {8'h00, 2'b00, c, 2'b00}, 1'b0, 16'h0000);
         cyc(2);
         vout_warn_clr = 2'b11;
         cyc(2);
         vout_warn_clr = 2'b00;
         cyc(1);
         chk({8'h00, vout_vid_a}, (c == 4'h5 || c == 4'h6) ? 16'h0011 :
             (c == 4'h9 || c == 4'hA) ? 16'h0050 : 16'h0033);
         chk({8'h00, vout_vid_b}, (c == 4'h5 || c == 4'h6) ? 16'h0011 :
             (c == 4'h9 || c == 4'hA) ? 16'h0070 : 16'h0033);
         chk({14'h0000, ovuv_mask_ff}, {14'h0000, {2{c == 4'h5 || c == 4'h9}}});
         chk({14'h0000, vout_max_warn_ff}, {14'h0000, {2{c == 4'hA}}});
      end
      acc(1'b1, 1'b0, 8'h01, 16'h0014, 1'b0, 16'h0000);
      onoff_use_cmd = 1'b0;
      cyc(3);
      chk({8'h00, vout_vid_a}, 16'h0033);
      chk({14'h0000, ovuv_mask_ff}, 16'h0000);
      chk({8'h00, vout_vid_b}, 16'h0033);
      chk({14'h0000, conv_en_ff}, 16'h0003);
   endtask : t_margin

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial
   begin
      n_mismatch = 0;
      checked = 0;
      rstn = 1'b0;
      onoff_use_cmd = 1'b1;
      onoff_use_pin = 1'b0;
      input_ok = 1'b1;
      chan_a_enable_pin = 1'b0;
      chan_b_enable_pin = 1'b0;
      vout_max_vid = 8'hA0;
      nvm_nominal_vid_a = 8'h60;
      nvm_nominal_vid_b = 8'hC0;
      margin_high_vid_a = 8'h50;
      margin_high_vid_b = 8'h70;
      vout_warn_clr = 2'b00;
      repeat (4) @(posedge clock);
      #1 rstn = 1'b1;
      cyc(2);
      t_reset();
      t_access();
      t_page();
      t_conv();
      t_ramp();
      t_margin();
      complete_run();
   end
endmodule : omc_margin_ctrl_test

`default_nettype wire
